// ===== rtl/sup_pkg.sv
// shared constants and types for the reset, watchdog and sleep supervisor
package sup_pkg;
	localparam int CLK_MHZ        = 200;
	localparam int HOLD_LONG_MS   = 18;
	localparam int HOLD_SHORT_US  = 10;
	localparam int WDT_PERIOD_MS  = 18;
	localparam int HOLD_LONG_CYC  = HOLD_LONG_MS * 1000 * CLK_MHZ;
	localparam int HOLD_SHORT_CYC = HOLD_SHORT_US * CLK_MHZ;
	localparam int WDT_PERIOD_CYC = WDT_PERIOD_MS * 1000 * CLK_MHZ;
	localparam int PRESCALE_BITS  = 7;

	localparam logic [7:0] ADDR_OPTION = 8'h00;
	localparam logic [7:0] ADDR_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	localparam logic [7:0] OPTION_RESET = 8'hFF;
	localparam int OPT_WAKE_EN_N_BIT = 7;
	localparam int OPT_PS_ASSIGN_BIT = 3;
	localparam int OPT_PS_SEL_LSB    = 0;

	localparam int CFG_WDT_FUSE_BIT = 0;
	localparam int CFG_EXT_EN_BIT   = 1;
	localparam int CFG_OSC_LSB      = 2;

	localparam int ST_SLEEP_BIT     = 0;
	localparam int ST_CORE_RST_BIT  = 1;
	localparam int ST_POWERDOWN_BIT = 3;
	localparam int ST_TIMEOUT_BIT   = 4;
	localparam int ST_PIN_WAKE_BIT  = 7;

	typedef enum logic [2:0]
	{
		LOW_POWER_CRYSTAL_MODE = 3'h0,
		STD_CRYSTAL_MODE       = 3'h1,
		FAST_CRYSTAL_MODE      = 3'h2,
		INTERNAL_OSC_MODE      = 3'h3,
		EXTERNAL_RC_MODE       = 3'h4,
		EXTERNAL_CLOCK_MODE    = 3'h5
	} osc_mode_t;

	typedef enum logic [1:0]
	{
		ST_HOLD  = 2'h0,
		ST_RUN   = 2'h1,
		ST_SLEEP = 2'h2
	} sup_state_t;

	localparam osc_mode_t OSC_RESET = INTERNAL_OSC_MODE;

	// crystal modes need the long hold after any reset; unknown codes take the long one too
	function automatic logic short_hold(input osc_mode_t m);
		short_hold = (m == INTERNAL_OSC_MODE) || (m == EXTERNAL_RC_MODE) || (m == EXTERNAL_CLOCK_MODE);
	endfunction
endpackage

// ===== rtl/sup_if.sv
// link between the supervisor control and its watchdog and hold timer
`timescale 1ns/1ps
interface sup_if;
	logic       wdt_clear;
	logic       wdt_enable;
	logic       ps_assign;
	logic [2:0] ps_sel;
	logic       wdt_timeout;
	logic       hold_start;
	logic       hold_long;
	logic       hold_busy;
	modport ctrl (output wdt_clear, wdt_enable, ps_assign, ps_sel, hold_start, hold_long,
		input wdt_timeout, hold_busy);
	modport wdt (input wdt_clear, wdt_enable, ps_assign, ps_sel, output wdt_timeout);
	modport hold (input hold_start, hold_long, output hold_busy);
endinterface

// ===== rtl/watchdog_core.sv
// watchdog counter with power-of-two prescaler
`timescale 1ns/1ps
module watchdog_core #(
	parameter int PERIOD_CYC = sup_pkg::WDT_PERIOD_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	sup_if.wdt       bus
);
	localparam int W = $clog2(PERIOD_CYC + 1);
	typedef struct packed {
		logic [sup_pkg::PRESCALE_BITS-1:0] pre;
		logic [W-1:0]                      count;
		logic                              fire;
	} wdt_state_t;
	wdt_state_t state_reg;
	wdt_state_t state_next;
	logic [7:0] ratio_m1;
	logic       tick;

	always_comb
	begin
		state_next = state_reg;
		state_next.fire = 1'b0;
		ratio_m1 = (8'h01 << bus.ps_sel) - 8'h01;
		tick = !bus.ps_assign || (state_reg.pre == ratio_m1[sup_pkg::PRESCALE_BITS-1:0]);
		if (bus.wdt_clear || !bus.wdt_enable)
		begin
			state_next.count = '0;
			if (bus.ps_assign || !bus.wdt_enable)
				state_next.pre = '0;
		end
		else
		begin
			if (bus.ps_assign)
				state_next.pre = tick ? '0 : state_reg.pre + 1'b1;
			if (tick)
			begin
				if (state_reg.count == W'(PERIOD_CYC - 1))
				begin
					state_next.count = '0;
					state_next.fire = 1'b1;
				end
				else
					state_next.count = state_reg.count + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign bus.wdt_timeout = state_reg.fire;

	property p_wdt_clear;
		@(posedge i_clk_sys) disable iff (i_rst)
		bus.wdt_clear && bus.ps_assign |=> state_reg.count == '0 && state_reg.pre == '0 && !state_reg.fire;
	endproperty
	a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");
endmodule

// ===== rtl/hold_timer.sv
// start-up hold timer, long or short period per start request
`timescale 1ns/1ps
module hold_timer #(
	parameter int LONG_CYC  = sup_pkg::HOLD_LONG_CYC,
	parameter int SHORT_CYC = sup_pkg::HOLD_SHORT_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	sup_if.hold      bus
);
	// wide enough for whichever period is longer, a short one may exceed a shortened long one
	localparam int W = $clog2((LONG_CYC > SHORT_CYC ? LONG_CYC : SHORT_CYC) + 1);
	typedef struct packed {
		logic [W-1:0] count;
	} hold_state_t;
	hold_state_t state_reg;
	hold_state_t state_next;

	always_comb
	begin
		state_next = state_reg;
		if (bus.hold_start)
			state_next.count = bus.hold_long ? W'(LONG_CYC) : W'(SHORT_CYC);
		else if (state_reg.count != '0)
			state_next.count = state_reg.count - 1'b1;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign bus.hold_busy = state_reg.count != '0;

	property p_hold_load;
		@(posedge i_clk_sys) disable iff (i_rst)
		bus.hold_start |=> state_reg.count == ($past(bus.hold_long) ? W'(LONG_CYC) : W'(SHORT_CYC));
	endproperty
	a_hold_load: assert property (p_hold_load) else $error("hold period loaded wrong");
endmodule

// ===== rtl/reset_watchdog_sleep_supervisor.sv
// reset, watchdog and sleep supervisor with apb register slave
`timescale 1ns/1ps
module reset_watchdog_sleep_supervisor #(
	parameter int N_WAKE         = 4,
	parameter int HOLD_LONG_CYC  = sup_pkg::HOLD_LONG_CYC,
	parameter int WDT_PERIOD_CYC = sup_pkg::WDT_PERIOD_CYC
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [7:0]        i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic      [31:0]       o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	input  wire logic              i_sleep_op,
	input  wire logic              i_clear_watchdog_op,
	input  wire logic              i_port_access_op,
	input  wire logic              i_ext_reset_n,
	input  wire logic [N_WAKE-1:0] i_wake_pins,
	output logic                   o_core_reset,
	output logic                   o_osc_enable,
	output logic                   o_io_hold,
	output logic                   o_sleeping,
	output logic                   o_timeout_flag_n,
	output logic                   o_powerdown_flag_n,
	output logic                   o_pin_wake_flag
);
	typedef struct packed {
		sup_pkg::sup_state_t st;
		logic                timeout_flag_n;
		logic                powerdown_flag_n;
		logic                pin_wake_flag;
		logic                start;
		logic                long_hold;
		logic                clr;
		logic [N_WAKE-1:0]   snap;
		logic [7:0]          option_config;
		logic                watchdog_enable_fuse;
		logic                ext_reset_enable;
		sup_pkg::osc_mode_t  osc;
	} ctl_state_t;

	localparam ctl_state_t CTL_RESET = '{
		st:                   sup_pkg::ST_HOLD,
		timeout_flag_n:       1'b1,
		powerdown_flag_n:     1'b1,
		pin_wake_flag:        1'b0,
		start:                1'b1,
		long_hold:            1'b1,
		clr:                  1'b1,
		snap:                 '0,
		option_config:        sup_pkg::OPTION_RESET,
		watchdog_enable_fuse: 1'b1,
		ext_reset_enable:     1'b1,
		osc:                  sup_pkg::OSC_RESET
	};

	ctl_state_t state_reg;
	ctl_state_t state_next;
	logic       ext_rst;
	logic       wake_chg;
	logic       apb_access;
	logic       quiet;

	sup_if link ();

	watchdog_core #(
		.PERIOD_CYC (WDT_PERIOD_CYC)
	) u_wdt (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.bus       (link.wdt)
	);

	hold_timer #(
		.LONG_CYC  (HOLD_LONG_CYC),
		.SHORT_CYC (sup_pkg::HOLD_SHORT_CYC)
	) u_hold (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.bus       (link.hold)
	);

	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == sup_pkg::ADDR_OPTION) || (a == sup_pkg::ADDR_CONFIG) || (a == sup_pkg::ADDR_STATUS);
	endfunction

	assign ext_rst    = state_reg.ext_reset_enable && !i_ext_reset_n;
	// compare against the snapshot, so a change never read before sleep wakes at once
	assign wake_chg   = !state_reg.option_config[sup_pkg::OPT_WAKE_EN_N_BIT]
		&& (i_wake_pins != state_reg.snap);
	assign apb_access = i_psel && i_penable;
	assign quiet      = !ext_rst && !link.wdt_timeout;

	always_comb
	begin
		// flags keep their value unless a reset cause or the sleep entry below rewrites them
		state_next = state_reg;
		state_next.start = 1'b0;
		state_next.clr = 1'b0;
		if (apb_access && i_pwrite)
		begin
			if (i_paddr == sup_pkg::ADDR_OPTION)
				state_next.option_config = i_pwdata[7:0];
			else if (i_paddr == sup_pkg::ADDR_CONFIG)
			begin
				state_next.watchdog_enable_fuse = i_pwdata[sup_pkg::CFG_WDT_FUSE_BIT];
				state_next.ext_reset_enable = i_pwdata[sup_pkg::CFG_EXT_EN_BIT];
				state_next.osc = sup_pkg::osc_mode_t'(i_pwdata[sup_pkg::CFG_OSC_LSB +: 3]);
			end
		end
		unique case (state_reg.st)
			sup_pkg::ST_HOLD:
			begin
				state_next.clr = 1'b1;
				// timer restarts for as long as the reset pin is held low
				if (ext_rst)
					state_next.start = 1'b1;
				else if (!state_reg.start && !link.hold_busy)
					state_next.st = sup_pkg::ST_RUN;
			end
			sup_pkg::ST_RUN:
			begin
				if (ext_rst)
					state_next.pin_wake_flag = 1'b0;
				else if (link.wdt_timeout)
				begin
					// internal only: nothing here reaches the reset pin
					state_next.pin_wake_flag = 1'b0;
					state_next.timeout_flag_n = 1'b0;
				end
				else if (i_sleep_op)
				begin
					state_next.st = sup_pkg::ST_SLEEP;
					state_next.timeout_flag_n = 1'b1;
					state_next.powerdown_flag_n = 1'b0;
					state_next.clr = 1'b1;
				end
				else
				begin
					if (i_clear_watchdog_op)
						state_next.clr = 1'b1;
					if (i_port_access_op)
						state_next.snap = i_wake_pins;
				end
			end
			sup_pkg::ST_SLEEP:
			begin
				if (ext_rst)
				begin
					state_next.pin_wake_flag = 1'b0;
					state_next.timeout_flag_n = 1'b1;
					state_next.powerdown_flag_n = 1'b0;
				end
				else if (link.wdt_timeout)
				begin
					state_next.pin_wake_flag = 1'b0;
					state_next.timeout_flag_n = 1'b0;
					state_next.powerdown_flag_n = 1'b0;
				end
				else if (wake_chg)
				begin
					state_next.pin_wake_flag = 1'b1;
					state_next.timeout_flag_n = 1'b1;
					state_next.powerdown_flag_n = 1'b0;
				end
			end
			default:
				state_next.st = sup_pkg::ST_HOLD;
		endcase
		// every reset source leaves through the hold timer with the option reloaded
		if (state_reg.st != sup_pkg::ST_HOLD && (ext_rst || link.wdt_timeout
			|| (state_reg.st == sup_pkg::ST_SLEEP && wake_chg)))
		begin
			state_next.st = sup_pkg::ST_HOLD;
			state_next.start = 1'b1;
			state_next.long_hold = !sup_pkg::short_hold(state_reg.osc);
			state_next.clr = 1'b1;
			state_next.option_config = sup_pkg::OPTION_RESET;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			state_reg <= CTL_RESET;
		else
			state_reg <= state_next;
	end

	assign link.wdt_clear  = state_reg.clr;
	assign link.wdt_enable = state_reg.watchdog_enable_fuse && state_reg.st != sup_pkg::ST_HOLD;
	assign link.ps_assign  = state_reg.option_config[sup_pkg::OPT_PS_ASSIGN_BIT];
	assign link.ps_sel     = state_reg.option_config[sup_pkg::OPT_PS_SEL_LSB +: 3];
	assign link.hold_start = state_reg.start;
	assign link.hold_long  = state_reg.long_hold;

	assign o_core_reset       = state_reg.st == sup_pkg::ST_HOLD;
	assign o_sleeping         = state_reg.st == sup_pkg::ST_SLEEP;
	assign o_io_hold          = o_sleeping;
	assign o_osc_enable       = !o_sleeping;
	assign o_timeout_flag_n   = state_reg.timeout_flag_n;
	assign o_powerdown_flag_n = state_reg.powerdown_flag_n;
	assign o_pin_wake_flag    = state_reg.pin_wake_flag;

	// zero wait state: every access completes in its first access cycle
	assign o_pready  = 1'b1;
	assign o_pslverr = apb_access && !addr_hit(i_paddr);

	always_comb
	begin
		o_prdata = 32'h0000_0000;
		if (i_psel && !i_pwrite)
		begin
			// option register is write only and reads as zero
			if (i_paddr == sup_pkg::ADDR_CONFIG)
			begin
				o_prdata[sup_pkg::CFG_WDT_FUSE_BIT] = state_reg.watchdog_enable_fuse;
				o_prdata[sup_pkg::CFG_EXT_EN_BIT] = state_reg.ext_reset_enable;
				o_prdata[sup_pkg::CFG_OSC_LSB +: 3] = state_reg.osc;
			end
			else if (i_paddr == sup_pkg::ADDR_STATUS)
			begin
				o_prdata[sup_pkg::ST_SLEEP_BIT] = o_sleeping;
				o_prdata[sup_pkg::ST_CORE_RST_BIT] = o_core_reset;
				o_prdata[sup_pkg::ST_POWERDOWN_BIT] = state_reg.powerdown_flag_n;
				o_prdata[sup_pkg::ST_TIMEOUT_BIT] = state_reg.timeout_flag_n;
				o_prdata[sup_pkg::ST_PIN_WAKE_BIT] = state_reg.pin_wake_flag;
			end
		end
	end

	// every check here is on the system clock and pauses during reset
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	sequence s_enter_sleep;
		o_sleeping == 1'b0 && !o_core_reset && quiet && i_sleep_op;
	endsequence
	sequence s_sleep_done;
		o_sleeping && !o_osc_enable && o_timeout_flag_n && !o_powerdown_flag_n && link.wdt_clear;
	endsequence
	sequence s_sleep_wdt_wake;
		o_sleeping && !ext_rst && link.wdt_timeout;
	endsequence
	sequence s_wake_reset;
		o_core_reset && link.hold_start && link.wdt_clear;
	endsequence

	property p_sleep_entry;
		s_enter_sleep |=> s_sleep_done;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");

	property p_sleep_clr;
		// a pending pin change may end sleep at once, so look at the counter, not the state
		s_enter_sleep |=> link.wdt_clear ##1 (u_wdt.state_reg.count == '0);
	endproperty
	a_sleep_clr: assert property (p_sleep_clr) else $error("sleep did not clear watchdog");

	property p_clear_watchdog_op;
		!o_sleeping && !o_core_reset && quiet && !i_sleep_op && i_clear_watchdog_op |=> link.wdt_clear;
	endproperty
	a_clear_watchdog_op: assert property (p_clear_watchdog_op) else $error("clear op lost");

	property p_wdt_wake;
		s_sleep_wdt_wake |=> s_wake_reset
			and (!o_pin_wake_flag && !o_timeout_flag_n && !o_powerdown_flag_n);
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake flags wrong");

	property p_wdt_run;
		!o_sleeping && !o_core_reset && !ext_rst && link.wdt_timeout |=> o_core_reset && !o_pin_wake_flag
			&& !o_timeout_flag_n && o_powerdown_flag_n == $past(o_powerdown_flag_n);
	endproperty
	a_wdt_run: assert property (p_wdt_run) else $error("watchdog reset flags wrong");

	property p_pin_sleep;
		o_sleeping && ext_rst |=> s_wake_reset
			and (!o_pin_wake_flag && o_timeout_flag_n && !o_powerdown_flag_n);
	endproperty
	a_pin_sleep: assert property (p_pin_sleep) else $error("reset pin wake flags wrong");

	property p_pin_run;
		!o_sleeping && !o_core_reset && ext_rst |=> o_core_reset && !o_pin_wake_flag
			&& $stable(o_timeout_flag_n) && $stable(o_powerdown_flag_n);
	endproperty
	a_pin_run: assert property (p_pin_run) else $error("reset pin run flags wrong");

	property p_chg_wake;
		o_sleeping && quiet && wake_chg |=> s_wake_reset
			and (o_pin_wake_flag && o_timeout_flag_n && !o_powerdown_flag_n);
	endproperty
	a_chg_wake: assert property (p_chg_wake) else $error("pin change wake wrong");

	property p_flags_hold;
		!o_core_reset && quiet && !i_sleep_op && !(o_sleeping && wake_chg) |=> $stable(o_timeout_flag_n)
			&& $stable(o_powerdown_flag_n) && $stable(o_pin_wake_flag);
	endproperty
	a_flags_hold: assert property (p_flags_hold) else $error("flag changed without reset");

	property p_fuse_off;
		!state_reg.watchdog_enable_fuse |-> !link.wdt_enable ##1 !link.wdt_timeout;
	endproperty
	a_fuse_off: assert property (p_fuse_off) else $error("disabled watchdog active");

	property p_short_hold;
		!o_core_reset && ext_rst && sup_pkg::short_hold(state_reg.osc) |=> link.hold_start && !link.hold_long;
	endproperty
	a_short_hold: assert property (p_short_hold) else $error("short hold not chosen");

	property p_hold_core;
		link.hold_busy |-> o_core_reset;
	endproperty
	a_hold_core: assert property (p_hold_core) else $error("core released during hold");
endmodule

// ===== test/core_model.sv
// behavioural processor core issuing sleep, clear and port operations
`timescale 1ns/1ps
module core_model (
	input  wire logic i_clk_sys,
	input  wire logic i_core_reset,
	output logic      o_sleep_op,
	output logic      o_clear_watchdog_op,
	output logic      o_port_access_op
);
	initial
	begin
		o_sleep_op = 1'b0;
		o_clear_watchdog_op = 1'b0;
		o_port_access_op = 1'b0;
	end

	// a core held in reset executes nothing, so every op waits up to 5000 cycles for release
	task automatic issue(input int kind);
		int n;
		n = 0;
		while (i_core_reset !== 1'b0 && n < 5000)
		begin
			@(posedge i_clk_sys);
			n++;
		end
		@(posedge i_clk_sys);
		o_sleep_op <= (kind == 0);
		o_clear_watchdog_op <= (kind == 1);
		o_port_access_op <= (kind >= 2);
		@(posedge i_clk_sys);
		o_sleep_op <= 1'b0;
		o_clear_watchdog_op <= 1'b0;
		o_port_access_op <= 1'b0;
	endtask

	// port read right before sleep, else a stale change wakes at once
	task automatic read_then_sleep();
		issue(2);
		issue(0);
	endtask
endmodule

// ===== test/reset_watchdog_sleep_supervisor_tb.sv
// self-checking bench for the reset, watchdog and sleep supervisor
`timescale 1ns/1ps
module reset_watchdog_sleep_supervisor_tb;
	localparam int HL = 50;
	localparam int WP = 40;
	localparam int HS = sup_pkg::HOLD_SHORT_CYC;
	logic        i_clk_sys = 1'b0;
	logic        i_rst     = 1'b1;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [7:0]  paddr     = 8'h00;
	logic [31:0] pwdata    = 32'h0;
	logic        ext_n     = 1'b1;
	logic [3:0]  pins      = 4'h0;
	wire logic [31:0] prdata;
	wire logic   pready, pslverr, core_reset, osc_en, io_hold, sleeping, to_n, pd_n, pw;
	wire logic   sleep_op, clr_op, port_op;
	int          failures  = 0;
	int          cmp_count = 0;
	int          seed      = 54;
	int          e_pw, e_to, e_pd, n;
	logic [31:0] rd;
	logic        err;
	logic [3:0]  v, d;

	always #2.5 i_clk_sys = ~i_clk_sys;

	reset_watchdog_sleep_supervisor #(.N_WAKE(4), .HOLD_LONG_CYC(HL), .WDT_PERIOD_CYC(WP))
	reset_watchdog_sleep_supervisor_i (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_sleep_op(sleep_op),
		.i_clear_watchdog_op(clr_op), .i_port_access_op(port_op), .i_ext_reset_n(ext_n),
		.i_wake_pins(pins), .o_core_reset(core_reset), .o_osc_enable(osc_en),
		.o_io_hold(io_hold), .o_sleeping(sleeping), .o_timeout_flag_n(to_n),
		.o_powerdown_flag_n(pd_n), .o_pin_wake_flag(pw)
	);

	core_model core_model_i (
		.i_clk_sys(i_clk_sys), .i_core_reset(core_reset), .o_sleep_op(sleep_op),
		.o_clear_watchdog_op(clr_op), .o_port_access_op(port_op)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %0t %s: seen %0h expected %0h", $time, msg, seen, exp);
		end
	endtask

	task automatic rng(input int lo, input int hi);
		chk(32'(n >= lo && n <= hi), 32'h1, "cycle count out of range");
	endtask

	// expected flags per reset cause or sleep entry
	task automatic flags(input int k);
		case (k)
			0: {e_pw, e_to, e_pd} = {32'd0, 32'd1, 32'd1};
			1: {e_to, e_pd} = {32'd1, 32'd0};
			2: {e_pw, e_to, e_pd} = {32'd0, 32'd0, 32'd0};
			3: {e_pw, e_to} = {32'd0, 32'd0};
			4: {e_pw, e_to, e_pd} = {32'd0, 32'd1, 32'd0};
			5: e_pw = 0;
			default: {e_pw, e_to, e_pd} = {32'd1, 32'd1, 32'd0};
		endcase
		chk({29'h0, pw, to_n, pd_n}, 32'(e_pw * 4 + e_to * 2 + e_pd), "status flags");
	endtask

	task automatic wait_cr(input logic val, input int lim);
		n = 0;
		while (core_reset !== val && n < lim)
		begin
			@(posedge i_clk_sys);
			#1;
			n++;
		end
	endtask

	task automatic hold(input int h);
		wait_cr(1'b0, h + 50);
		rng(h, h + 4);
	endtask

	task automatic wdt_to(input int s);
		wait_cr(1'b1, (WP << s) + (1 << s) + 50);
		rng((WP << s) - 1, (WP << s) + (1 << s) + 4);
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
		int k;
		k = 0;
		@(posedge i_clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dat;
		@(posedge i_clk_sys);
		penable <= 1'b1;
		do
		begin
			@(posedge i_clk_sys);
			k++;
		end
		while (pready !== 1'b1 && k < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic ext_pulse();
		@(posedge i_clk_sys);
		ext_n <= 1'b0;
		@(posedge i_clk_sys);
		ext_n <= 1'b1;
		wait_cr(1'b1, 10);
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		repeat (6) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		#1;
		flags(0);
		chk(32'(core_reset), 32'h1, "core held at power-up");
		hold(HL);
		apb(1'b0, sup_pkg::ADDR_CONFIG, 32'h0);
		chk(rd, 32'h0000000F, "config reset value");
		chk(32'(err), 32'h0, "mapped address");
		chk(32'(pready), 32'h1, "no wait states");
		apb(1'b0, sup_pkg::ADDR_OPTION, 32'h0);
		chk(rd, 32'h0, "option is write only");
		apb(1'b1, sup_pkg::ADDR_STATUS, 32'h0);
		apb(1'b0, sup_pkg::ADDR_STATUS, 32'h0);
		chk(rd, 32'h00000018, "status after power-up");
		apb(1'b0, 8'h0C, 32'h0);
		chk(32'(err), 32'h1, "unmapped address");
		// repeated clears keep the unprescaled watchdog from expiring
		apb(1'b1, sup_pkg::ADDR_OPTION, 32'h00000080);
		repeat (4)
		begin
			repeat (30) @(posedge i_clk_sys);
			core_model_i.issue(1);
		end
		#1;
		chk(32'(core_reset), 32'h0, "clear prevents time-out");
		wdt_to(0);
		flags(3);
		hold(HS);
		for (int s = 0; s < 8; s++)
		begin
			apb(1'b1, sup_pkg::ADDR_OPTION, 32'h00000088 | 32'(s));
			core_model_i.issue(1);
			wdt_to(s);
			hold(HS);
		end
		apb(1'b1, sup_pkg::ADDR_OPTION, 32'h00000080);
		core_model_i.issue(0);
		#1;
		chk({29'h0, sleeping, io_hold, osc_en}, 32'h6, "sleep outputs");
		flags(1);
		wdt_to(0);
		flags(2);
		hold(HS);
		apb(1'b1, sup_pkg::ADDR_CONFIG, 32'h00000007);
		ext_pulse();
		flags(5);
		hold(HL);
		apb(1'b1, sup_pkg::ADDR_CONFIG, 32'h0000000E);
		apb(1'b1, sup_pkg::ADDR_OPTION, 32'h00000080);
		repeat (100) @(posedge i_clk_sys);
		#1;
		chk(32'(core_reset), 32'h0, "disabled watchdog running");
		core_model_i.issue(0);
		repeat (100) @(posedge i_clk_sys);
		#1;
		chk(32'(sleeping), 32'h1, "disabled watchdog asleep");
		ext_pulse();
		flags(4);
		hold(HS);
		apb(1'b1, sup_pkg::ADDR_CONFIG, 32'h0000000F);
		apb(1'b1, sup_pkg::ADDR_OPTION, 32'h0000000F);
		v = 4'($random(seed));
		d = 4'((($random(seed) & 32'h7FFF) % 15) + 1);
		@(posedge i_clk_sys);
		pins <= v;
		core_model_i.read_then_sleep();
		repeat (10) @(posedge i_clk_sys);
		#1;
		chk(32'(sleeping), 32'h1, "no change keeps sleep");
		@(posedge i_clk_sys);
		pins <= v ^ d;
		wait_cr(1'b1, 10);
		flags(6);
		hold(HS);
		apb(1'b1, sup_pkg::ADDR_OPTION, 32'h0000000F);
		core_model_i.issue(0);
		wait_cr(1'b1, 6);
		rng(0, 4);
		flags(6);
		hold(HS);
		close_out();
	end

	initial
	begin
		repeat (60000) @(posedge i_clk_sys);
		failures++;
		close_out();
	end
endmodule
